// ---- audc_defines.svh ----
// Register offsets, indices, masks and reset values of the codec control bank.
// What this block does
// - RAM modulo size sits in bits 5:0, 512 locations per unit; 7:6 zero.
// - Master bit clock rate code: 00 3.072, 01 6.144, 10 12.288 MHz.
// - Master frame rate code: 00 48, 01 96, 10 192 kHz.
// - Output bit 13 swaps which frame clock level carries left data.
// - Output bit 12 picks the bit clock edge where output data changes.
// - Output port is slave after reset; master bit drives both clock pins.
// - Output bit 6 picks word clock or one bit wide frame pulse.
// - MSB delay codes 000..100 give 1, 0, 8, 12, 16 bit clocks.
// - Input bits 2:0 pick I2S, left, TDM or right-justified formats.
// - Input bit 4 swaps which frame clock level captures left data.
// - Input bit 3 picks data change edge; sampling uses the other edge.
// - Converter bits 6:5 route input line 3, 2, 1 or 0.
// - Converter port has same formats, code 010 reserved, own polarity bits.
// - Power bits power up when one; all powered down after reset.
// - Power bits map PLL, reference, converters, headphone, rate converter, engine.
// - User one bits 12:9 always read as ones, default readback 0x1e00.
// - User one bit 7 shows rate converter lock, read only.
// - User one bit 6 enables master clock out, bits 5:3 pick its rate.
// - User one bits 2:1 pick PLL input clock, bit 0 uses the PLL.
`ifndef AUDC_DEFINES_SVH
`define AUDC_DEFINES_SVH
`define AUDC_OFS_MODULO 16'h1053
`define AUDC_OFS_SOUT 16'h1054
`define AUDC_OFS_SIN 16'h1055
`define AUDC_OFS_CONV 16'h1056
`define AUDC_OFS_MUX 16'h1057
`define AUDC_OFS_POWER 16'h1058
`define AUDC_OFS_USER1 16'h1059
`define AUDC_OFS_USER2 16'h105a
`define AUDC_OFS_DACAMP 16'h110d
`define AUDC_OFS_HPAMP 16'h1113
`define AUDC_IX_MODULO 4'h0
`define AUDC_IX_SOUT 4'h1
`define AUDC_IX_SIN 4'h2
`define AUDC_IX_CONV 4'h3
`define AUDC_IX_MUX 4'h4
`define AUDC_IX_POWER 4'h5
`define AUDC_IX_USER1 4'h6
`define AUDC_IX_USER2 4'h7
`define AUDC_IX_DACAMP 4'h8
`define AUDC_IX_HPAMP 4'h9
`define AUDC_IX_NONE 4'hf
`define AUDC_NREG 10
`define AUDC_MSK_MODULO 16'h003f
`define AUDC_MSK_SOUT 16'hffff
`define AUDC_MSK_SIN 16'h003f
`define AUDC_MSK_CONV 16'h007f
`define AUDC_MSK_MUX 16'h000f
`define AUDC_MSK_POWER 16'hffff
`define AUDC_MSK_USER1 16'h017f
`define AUDC_MSK_USER2 16'h009f
`define AUDC_MSK_DACAMP 16'h0010
`define AUDC_MSK_HPAMP 16'h0001
`define AUDC_RST_MODULO 16'h0028
`define AUDC_RST_USER1 16'h1e00
`define AUDC_RST_ZERO 16'h0000
`define AUDC_U1_ONES 4'hf
`define AUDC_U1_LOCK_BIT 7
`endif

// ---- audc_pkg.sv ----
// Types shared by the codec control bank.
package audc_pkg;
   typedef struct packed {
      logic dither;
      logic tdm16;
      logic frame_swap;
      logic bclk_rise;
      logic master;
      logic [1:0] bclk_rate;
      logic [1:0] frame_rate;
      logic pulse_sync;
      logic tdm_en;
      logic [2:0] msb_pos;
      logic [1:0] word_len;
   } audc_sout_t;
   typedef struct packed {
      logic [1:0] rsvd;
      logic tdm16;
      logic frame_swap;
      logic bclk_rise;
      logic [2:0] mode;
   } audc_sin_t;
   typedef struct packed {
      logic rsvd;
      logic [1:0] line_sel;
      logic frame_swap;
      logic bclk_rise;
      logic [2:0] mode;
   } audc_conv_t;
   typedef struct packed {
      logic pll;
      logic ref_buf;
      logic adc;
      logic [7:0] dac;
      logic [1:0] hp_amp;
      logic rate_conv;
      logic engine;
      logic dsp;
   } audc_power_t;
   typedef struct packed {
      logic [6:0] rsvd;
      logic mux_en;
      logic lock;
      logic mclk_en;
      logic [2:0] mclk_sel;
      logic [1:0] pll_src;
      logic pll_en;
   } audc_user1_t;
   typedef struct packed {
      logic [7:0] rsvd;
      logic mute;
      logic [1:0] rsvd2;
      logic [4:0] atten;
   } audc_user2_t;
   typedef enum logic {AUDC_LK_IDLE, AUDC_LK_WAIT} audc_link_st_t;
endpackage

// ---- audc_regs.sv ----
// Control register bank of the codec, with its control-port link domain.
`timescale 1ns/1ps
`include "audc_defines.svh"
module audc_regs
   import audc_pkg::*;
(
   // Core clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control port link, decoded word transactions.
   input wire logic ctl_clk,
   input wire logic ctl_wr_stb,
   input wire logic ctl_rd_stb,
   input wire logic [15:0] ctl_addr,
   input wire logic [15:0] ctl_wdata,
   output logic [15:0] ctl_rdata,
   output logic ctl_done,
   output logic ctl_busy,
   // Status from the rate converter.
   input wire logic rate_converter_lock,
   // Configuration outputs.
   output audc_sout_t sout_cfg,
   output audc_sin_t sin_cfg,
   output audc_conv_t conv_cfg,
   output audc_power_t power_cfg,
   output audc_user1_t user1_cfg,
   output audc_user2_t user2_cfg,
   output logic [3:0] analog_input_sel,
   output logic [5:0] modulo_blocks,
   output logic output_amp_chop_off,
   output logic headphone_amp_chop_off,
   // Decoded output framing and routing.
   output logic [4:0] msb_delay,
   output logic [4:0] word_bits,
   output logic [1:0] rate_converter_line,
   // Pin drive enables, low while driving.
   output logic shared_bit_clock_pin_oe_n,
   output logic shared_frame_clock_pin_oe_n,
   output logic master_clock_out_pin_oe_n
);

////////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] reg_index(input logic [15:0] a);
      case (a)
         `AUDC_OFS_MODULO: reg_index = `AUDC_IX_MODULO;
         `AUDC_OFS_SOUT: reg_index = `AUDC_IX_SOUT;
         `AUDC_OFS_SIN: reg_index = `AUDC_IX_SIN;
         `AUDC_OFS_CONV: reg_index = `AUDC_IX_CONV;
         `AUDC_OFS_MUX: reg_index = `AUDC_IX_MUX;
         `AUDC_OFS_POWER: reg_index = `AUDC_IX_POWER;
         `AUDC_OFS_USER1: reg_index = `AUDC_IX_USER1;
         `AUDC_OFS_USER2: reg_index = `AUDC_IX_USER2;
         `AUDC_OFS_DACAMP: reg_index = `AUDC_IX_DACAMP;
         `AUDC_OFS_HPAMP: reg_index = `AUDC_IX_HPAMP;
         default: reg_index = `AUDC_IX_NONE;
      endcase
   endfunction

   // Reserved and read-only bits are kept out of every write.
   function automatic logic [15:0] wr_mask(input logic [3:0] ix);
      case (ix)
         `AUDC_IX_MODULO: wr_mask = `AUDC_MSK_MODULO;
         `AUDC_IX_SOUT: wr_mask = `AUDC_MSK_SOUT;
         `AUDC_IX_SIN: wr_mask = `AUDC_MSK_SIN;
         `AUDC_IX_CONV: wr_mask = `AUDC_MSK_CONV;
         `AUDC_IX_MUX: wr_mask = `AUDC_MSK_MUX;
         `AUDC_IX_POWER: wr_mask = `AUDC_MSK_POWER;
         `AUDC_IX_USER1: wr_mask = `AUDC_MSK_USER1;
         `AUDC_IX_USER2: wr_mask = `AUDC_MSK_USER2;
         `AUDC_IX_DACAMP: wr_mask = `AUDC_MSK_DACAMP;
         `AUDC_IX_HPAMP: wr_mask = `AUDC_MSK_HPAMP;
         default: wr_mask = `AUDC_RST_ZERO;
      endcase
   endfunction

   function automatic logic [15:0] rst_value(input logic [3:0] ix);
      case (ix)
         `AUDC_IX_MODULO: rst_value = `AUDC_RST_MODULO;
         `AUDC_IX_USER1: rst_value = `AUDC_RST_USER1;
         default: rst_value = `AUDC_RST_ZERO;
      endcase
   endfunction

   function automatic logic [4:0] msb_delay_of(input logic [2:0] c);
      case (c)
         3'h0: msb_delay_of = 5'h01;
         3'h1: msb_delay_of = 5'h00;
         3'h2: msb_delay_of = 5'h08;
         3'h3: msb_delay_of = 5'h0c;
         3'h4: msb_delay_of = 5'h10;
         default: msb_delay_of = 5'h00;
      endcase
   endfunction

   function automatic logic [4:0] word_bits_of(input logic [1:0] c);
      case (c)
         2'h0: word_bits_of = 5'h18;
         2'h1: word_bits_of = 5'h14;
         default: word_bits_of = 5'h10;
      endcase
   endfunction

////////////////////////////////////////////////////////////////////////////////
   // Link domain: a request is held stable until the core answers, so the
   // core may read the held words directly once the toggle has crossed.
   audc_link_st_t lk_st_r, lk_st_nxt;
   logic lk_req_r, lk_req_nxt;
   logic lk_wr_r, lk_wr_nxt;
   logic [15:0] lk_addr_r, lk_addr_nxt;
   logic [15:0] lk_wdata_r, lk_wdata_nxt;
   logic [15:0] lk_rdata_r, lk_rdata_nxt;
   logic lk_done_r, lk_done_nxt;
   logic lk_ack_s1_r, lk_ack_s2_r, lk_ack_s3_r;
   logic lk_ack_seen_r, lk_ack_seen_nxt;
   logic lk_ack_evt;
   logic co_ack_r, co_ack_nxt;
   logic [15:0] co_rdata_r, co_rdata_nxt;

   assign lk_ack_evt = (lk_ack_s2_r == lk_ack_s3_r) && (lk_ack_s3_r != lk_ack_seen_r);

   always_comb begin
      lk_st_nxt = lk_st_r;
      lk_req_nxt = lk_req_r;
      lk_wr_nxt = lk_wr_r;
      lk_addr_nxt = lk_addr_r;
      lk_wdata_nxt = lk_wdata_r;
      lk_rdata_nxt = lk_rdata_r;
      lk_done_nxt = 1'b0;
      lk_ack_seen_nxt = lk_ack_seen_r;
      case (lk_st_r)
         AUDC_LK_IDLE: begin
            if (ctl_wr_stb || ctl_rd_stb) begin
               lk_wr_nxt = ctl_wr_stb;
               lk_addr_nxt = ctl_addr;
               lk_wdata_nxt = ctl_wdata;
               lk_req_nxt = !lk_req_r;
               lk_st_nxt = AUDC_LK_WAIT;
            end
         end
         AUDC_LK_WAIT: begin
            if (lk_ack_evt) begin
               lk_ack_seen_nxt = lk_ack_s3_r;
               lk_rdata_nxt = co_rdata_r;
               lk_done_nxt = 1'b1;
               lk_st_nxt = AUDC_LK_IDLE;
            end
         end
         default: lk_st_nxt = AUDC_LK_IDLE;
      endcase
   end

   always_ff @(posedge ctl_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lk_st_r <= AUDC_LK_IDLE;
         lk_req_r <= 1'b0;
         lk_wr_r <= 1'b0;
         lk_addr_r <= 16'h0000;
         lk_wdata_r <= 16'h0000;
         lk_rdata_r <= 16'h0000;
         lk_done_r <= 1'b0;
         lk_ack_s1_r <= 1'b0;
         lk_ack_s2_r <= 1'b0;
         lk_ack_s3_r <= 1'b0;
         lk_ack_seen_r <= 1'b0;
      end else begin
         lk_st_r <= lk_st_nxt;
         lk_req_r <= lk_req_nxt;
         lk_wr_r <= lk_wr_nxt;
         lk_addr_r <= lk_addr_nxt;
         lk_wdata_r <= lk_wdata_nxt;
         lk_rdata_r <= lk_rdata_nxt;
         lk_done_r <= lk_done_nxt;
         lk_ack_s1_r <= co_ack_r;
         lk_ack_s2_r <= lk_ack_s1_r;
         lk_ack_s3_r <= lk_ack_s2_r;
         lk_ack_seen_r <= lk_ack_seen_nxt;
      end
   end

   assign ctl_rdata = lk_rdata_r;
   assign ctl_done = lk_done_r;
   assign ctl_busy = (lk_st_r == AUDC_LK_WAIT);

////////////////////////////////////////////////////////////////////////////////
   // Core domain: register file, request crossing and lock status crossing.
   logic [15:0] regs_r [`AUDC_NREG];
   logic [15:0] regs_nxt [`AUDC_NREG];
   logic co_req_s1_r, co_req_s2_r, co_req_s3_r;
   logic co_req_seen_r, co_req_seen_nxt;
   logic co_lk_s1_r, co_lk_s2_r, co_lk_s3_r;
   logic co_lock_r, co_lock_nxt;
   logic [4:0] msb_dly_r, msb_dly_nxt;
   logic [4:0] word_bits_r, word_bits_nxt;
   logic [1:0] conv_line_r, conv_line_nxt;
   logic bclk_oe_n_r, bclk_oe_n_nxt;
   logic frame_oe_n_r, frame_oe_n_nxt;
   logic mclk_oe_n_r, mclk_oe_n_nxt;
   logic co_req_evt;
   logic [3:0] co_ix;
   audc_sout_t sout_w;
   audc_user1_t user1_w;
   audc_conv_t conv_w;

   assign co_req_evt = (co_req_s2_r == co_req_s3_r) && (co_req_s3_r != co_req_seen_r);
   assign co_ix = reg_index(lk_addr_r);
   assign sout_w = audc_sout_t'(regs_r[`AUDC_IX_SOUT]);
   assign user1_w = audc_user1_t'(regs_r[`AUDC_IX_USER1]);
   assign conv_w = audc_conv_t'(regs_r[`AUDC_IX_CONV][7:0]);

   always_comb begin
      logic [15:0] m;
      m = wr_mask(co_ix);
      for (int i = 0; i < `AUDC_NREG; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      co_req_seen_nxt = co_req_seen_r;
      co_ack_nxt = co_ack_r;
      co_rdata_nxt = co_rdata_r;
      co_lock_nxt = co_lock_r;
      if (co_lk_s2_r == co_lk_s3_r) begin
         co_lock_nxt = co_lk_s3_r;
      end
      if (co_req_evt) begin
         co_req_seen_nxt = co_req_s3_r;
         co_ack_nxt = !co_ack_r;
         if (co_ix == `AUDC_IX_NONE) begin
            co_rdata_nxt = 16'h0000;
         end else if (lk_wr_r) begin
            regs_nxt[co_ix] = (regs_r[co_ix] & ~m) | (lk_wdata_r & m);
         end else begin
            co_rdata_nxt = regs_r[co_ix];
         end
      end
      // The lock flag is owned by hardware; a write in the same cycle loses.
      regs_nxt[`AUDC_IX_USER1][`AUDC_U1_LOCK_BIT] = co_lock_r;
      msb_dly_nxt = msb_delay_of(sout_w.msb_pos);
      word_bits_nxt = word_bits_of(sout_w.word_len);
      conv_line_nxt = 2'h3 - conv_w.line_sel;
      bclk_oe_n_nxt = !sout_w.master;
      frame_oe_n_nxt = !sout_w.master;
      mclk_oe_n_nxt = !user1_w.mclk_en;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < `AUDC_NREG; i++) begin
            regs_r[i] <= rst_value(4'(i));
         end
         co_req_s1_r <= 1'b0;
         co_req_s2_r <= 1'b0;
         co_req_s3_r <= 1'b0;
         co_req_seen_r <= 1'b0;
         co_ack_r <= 1'b0;
         co_rdata_r <= 16'h0000;
         co_lk_s1_r <= 1'b0;
         co_lk_s2_r <= 1'b0;
         co_lk_s3_r <= 1'b0;
         co_lock_r <= 1'b0;
         msb_dly_r <= 5'h01;
         word_bits_r <= 5'h18;
         conv_line_r <= 2'h3;
         bclk_oe_n_r <= 1'b1;
         frame_oe_n_r <= 1'b1;
         mclk_oe_n_r <= 1'b1;
      end else begin
         for (int i = 0; i < `AUDC_NREG; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
         co_req_s1_r <= lk_req_r;
         co_req_s2_r <= co_req_s1_r;
         co_req_s3_r <= co_req_s2_r;
         co_req_seen_r <= co_req_seen_nxt;
         co_ack_r <= co_ack_nxt;
         co_rdata_r <= co_rdata_nxt;
         co_lk_s1_r <= rate_converter_lock;
         co_lk_s2_r <= co_lk_s1_r;
         co_lk_s3_r <= co_lk_s2_r;
         co_lock_r <= co_lock_nxt;
         msb_dly_r <= msb_dly_nxt;
         word_bits_r <= word_bits_nxt;
         conv_line_r <= conv_line_nxt;
         bclk_oe_n_r <= bclk_oe_n_nxt;
         frame_oe_n_r <= frame_oe_n_nxt;
         mclk_oe_n_r <= mclk_oe_n_nxt;
      end
   end

   // Fields reach the datapath as the register flops themselves.
   assign sout_cfg = sout_w;
   assign sin_cfg = audc_sin_t'(regs_r[`AUDC_IX_SIN][7:0]);
   assign conv_cfg = conv_w;
   assign power_cfg = audc_power_t'(regs_r[`AUDC_IX_POWER]);
   assign user1_cfg = user1_w;
   assign user2_cfg = audc_user2_t'(regs_r[`AUDC_IX_USER2]);
   assign analog_input_sel = regs_r[`AUDC_IX_MUX][3:0];
   assign modulo_blocks = regs_r[`AUDC_IX_MODULO][5:0];
   assign output_amp_chop_off = regs_r[`AUDC_IX_DACAMP][4];
   assign headphone_amp_chop_off = regs_r[`AUDC_IX_HPAMP][0];
   assign msb_delay = msb_dly_r;
   assign word_bits = word_bits_r;
   assign rate_converter_line = conv_line_r;
   assign shared_bit_clock_pin_oe_n = bclk_oe_n_r;
   assign shared_frame_clock_pin_oe_n = frame_oe_n_r;
   assign master_clock_out_pin_oe_n = mclk_oe_n_r;

////////////////////////////////////////////////////////////////////////////////
   chk_oe_follow_master: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 (shared_bit_clock_pin_oe_n == !$past(sout_w.master))
      && (shared_frame_clock_pin_oe_n == !$past(sout_w.master)))
      else $error("clock pin enables do not follow master bit");
   chk_ones_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_USER1][12:9] == `AUDC_U1_ONES)
      else $error("user one bits 12:9 not ones");
   chk_lock_mirror: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 regs_r[`AUDC_IX_USER1][`AUDC_U1_LOCK_BIT] == $past(co_lock_r))
      else $error("lock flag does not mirror synchronised lock");
   chk_modulo_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_MODULO][7:6] == 2'h0)
      else $error("modulo reserved bits set");
   chk_power_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      co_req_evt && lk_wr_r && co_ix == `AUDC_IX_POWER |=> regs_r[`AUDC_IX_POWER] == $past(lk_wdata_r))
      else $error("power write not stored");
   chk_msb_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sout_w.msb_pos == 3'h2 |=> msb_delay == 5'h08)
      else $error("msb delay code 010 not eight");
   chk_word_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sout_w.word_len == 2'h1 |=> word_bits == 5'h14)
      else $error("word length code 01 not twenty");
   chk_hp_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_USER2][15:8] == 8'h00 && regs_r[`AUDC_IX_USER2][6:5] == 2'h0)
      else $error("user two reserved bits set");
   chk_line_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
      conv_w.line_sel == 2'h0 |=> rate_converter_line == 2'h3)
      else $error("converter line select 00 not line 3");
   chk_link_answer: assert property (@(posedge ctl_clk) disable iff (sys_rst)
      lk_st_r == AUDC_LK_IDLE && (ctl_wr_stb || ctl_rd_stb) |=> ##[1:12] ctl_done)
      else $error("control request not answered");

   // Reserved bits must stay zero, since reset clears them and the write masks keep them clear; the master clock pin, line and decodes must follow their fields.
   chk_sin_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_SIN][15:6] == 10'h000)
      else $error("serial input reserved bits set");
   chk_conv_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_CONV][15:7] == 9'h000)
      else $error("converter port reserved bits set");
   chk_mux_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_MUX][15:4] == 12'h000)
      else $error("input mux reserved bits set");
   chk_user1_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regs_r[`AUDC_IX_USER1][15:13] == 3'h0)
      else $error("user one bits 15:13 set");
   chk_mclk_oe: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 master_clock_out_pin_oe_n == !$past(user1_w.mclk_en))
      else $error("master clock pin enable does not follow bit 6");
   chk_line_last: assert property (@(posedge ref_clk) disable iff (sys_rst)
      conv_w.line_sel == 2'h3 |=> rate_converter_line == 2'h0)
      else $error("converter line select 11 not line 0");
   chk_msb_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sout_w.msb_pos == 3'h1 |=> msb_delay == 5'h00)
      else $error("msb delay code 001 not zero");
   chk_word_short: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sout_w.word_len[1] |=> word_bits == 5'h10)
      else $error("word length code 1x not sixteen");

   cov_power_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
      co_req_evt && lk_wr_r && co_ix == `AUDC_IX_POWER);
   cov_master_on: cover property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(sout_w.master) ##1 !shared_bit_clock_pin_oe_n);
   cov_user1_read: cover property (@(posedge ctl_clk) disable iff (sys_rst)
      ctl_done && lk_addr_r == `AUDC_OFS_USER1 && !lk_wr_r);
   cov_lock_rise: cover property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(regs_r[`AUDC_IX_USER1][`AUDC_U1_LOCK_BIT]));
endmodule // audc_regs

// ---- audc_host_model.sv ----
// Control-port host model: makes the link clock and issues one word transfer at a time.
`timescale 1ns/1ps
module audc_host_model (
   // Link outputs.
   output logic ctl_clk,
   output logic ctl_wr_stb,
   output logic ctl_rd_stb,
   output logic [15:0] ctl_addr,
   output logic [15:0] ctl_wdata,
   // Link answer.
   input wire logic ctl_done
);
   logic run;
   int timeouts;
   ////////////////////////////////////////////////////////////
   // The link clock stands low outside transfers, as a real host would leave it.
   initial begin
      run = 1'b0;
      timeouts = 0;
      ctl_clk = 1'b0;
      ctl_wr_stb = 1'b0;
      ctl_rd_stb = 1'b0;
      ctl_addr = 16'h0000;
      ctl_wdata = 16'h0000;
      #3.7;
      forever begin
         #15;
         ctl_clk = run ? ~ctl_clk : 1'b0;
      end
   end
   task automatic clk_run(input logic on);
      run = on;
   endtask
   ////////////////////////////////////////////////////////////
   // Released address and data lines carry the inverse of the last value and strobes drop low, so a design that samples late sees garbage.
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d, input int gap);
      int n;
      run = 1'b1;
      repeat (gap + 1) @(posedge ctl_clk);
      ctl_wr_stb <= wr;
      ctl_rd_stb <= ~wr;
      ctl_addr <= a;
      ctl_wdata <= d;
      @(posedge ctl_clk);
      ctl_wr_stb <= 1'b0;
      ctl_rd_stb <= 1'b0;
      ctl_addr <= ~a;
      ctl_wdata <= ~d;
      n = 0;
      while (ctl_done !== 1'b1 && n < 14) begin
         @(posedge ctl_clk);
         n++;
      end
      if (n >= 14) begin
         timeouts++;
      end
      @(posedge ctl_clk);
      run = 1'b0;
   endtask
endmodule // audc_host_model

// ---- audc_regs_tb.sv ----
// Self-checking bench of the codec control bank.
`timescale 1ns/1ps
`include "audc_defines.svh"
module audc_regs_tb
   import audc_pkg::*;
;
   logic ref_clk, sys_rst, ctl_clk, ctl_wr_stb, ctl_rd_stb, ctl_done, ctl_busy, rate_converter_lock;
   logic [15:0] ctl_addr, ctl_wdata, ctl_rdata, d, e;
   audc_sout_t sout_cfg;
   audc_sin_t sin_cfg;
   audc_conv_t conv_cfg;
   audc_power_t power_cfg;
   audc_user1_t user1_cfg;
   audc_user2_t user2_cfg;
   logic [3:0] analog_input_sel;
   logic [5:0] modulo_blocks;
   logic output_amp_chop_off, headphone_amp_chop_off, bclk_oe_n, fclk_oe_n, mclk_oe_n, rd_pend;
   logic [4:0] msb_delay, word_bits;
   logic [1:0] rate_converter_line;
   logic [15:0] ofs [11];
   logic [15:0] msk [11];
   logic [15:0] rst [11];
   logic [15:0] expq [$];
   int miscompares, compares, cycles;
   ////////////////////////////////////////////////////////////
   audc_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ctl_clk(ctl_clk), .ctl_wr_stb(ctl_wr_stb),
      .ctl_rd_stb(ctl_rd_stb), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
      .ctl_done(ctl_done), .ctl_busy(ctl_busy), .rate_converter_lock(rate_converter_lock),
      .sout_cfg(sout_cfg), .sin_cfg(sin_cfg), .conv_cfg(conv_cfg), .power_cfg(power_cfg),
      .user1_cfg(user1_cfg), .user2_cfg(user2_cfg), .analog_input_sel(analog_input_sel),
      .modulo_blocks(modulo_blocks), .output_amp_chop_off(output_amp_chop_off),
      .headphone_amp_chop_off(headphone_amp_chop_off), .msb_delay(msb_delay), .word_bits(word_bits),
      .rate_converter_line(rate_converter_line), .shared_bit_clock_pin_oe_n(bclk_oe_n),
      .shared_frame_clock_pin_oe_n(fclk_oe_n), .master_clock_out_pin_oe_n(mclk_oe_n));
   audc_host_model HOST (.ctl_clk(ctl_clk), .ctl_wr_stb(ctl_wr_stb), .ctl_rd_stb(ctl_rd_stb),
      .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_done(ctl_done));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic rd(input int i, input logic [15:0] exp);
      expq.push_back(exp);
      HOST.xfer(1'b0, ofs[i], 16'h0000, $urandom % 3);
   endtask
   task automatic wr(input int i, input logic [15:0] v);
      HOST.xfer(1'b1, ofs[i], v, $urandom % 3);
   endtask
   function automatic logic [15:0] cfg(input int i);
      case (i)
         0: cfg = {10'h000, modulo_blocks};
         1: cfg = sout_cfg;
         2: cfg = {8'h00, sin_cfg};
         3: cfg = {8'h00, conv_cfg};
         4: cfg = {12'h000, analog_input_sel};
         5: cfg = power_cfg;
         6: cfg = user1_cfg;
         7: cfg = user2_cfg;
         8: cfg = {11'h000, output_amp_chop_off, 4'h0};
         default: cfg = {15'h0000, headphone_amp_chop_off};
      endcase
   endfunction
   function automatic logic [4:0] msb_exp(input logic [2:0] c);
      case (c)
         3'h0: msb_exp = 5'h01;
         3'h1: msb_exp = 5'h00;
         3'h2: msb_exp = 5'h08;
         3'h3: msb_exp = 5'h0c;
         3'h4: msb_exp = 5'h10;
         default: msb_exp = 5'h00;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////
   // Read answers are matched in order against the notes left by the driver.
   always @(posedge ctl_clk) begin
      if (ctl_busy === 1'b0 && (ctl_wr_stb | ctl_rd_stb) === 1'b1) begin
         rd_pend <= ~ctl_wr_stb;
      end
      if (ctl_done === 1'b1 && rd_pend === 1'b1) begin
         if (expq.size() == 0) begin
            check(ctl_rdata, 16'hxxxx, "unexpected read");
         end else begin
            check(ctl_rdata, expq.pop_front(), "read data");
         end
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         $display("Error at %0t: run did not finish", $time);
         results();
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      rate_converter_lock = 1'b0;
      rd_pend = 1'b0;
      miscompares = 0;
      compares = 0;
      cycles = 0;
      ofs = '{`AUDC_OFS_MODULO, `AUDC_OFS_SOUT, `AUDC_OFS_SIN, `AUDC_OFS_CONV, `AUDC_OFS_MUX,
         `AUDC_OFS_POWER, `AUDC_OFS_USER1, `AUDC_OFS_USER2, `AUDC_OFS_DACAMP, `AUDC_OFS_HPAMP, 16'h1052};
      msk = '{16'h003f, 16'hffff, 16'h003f, 16'h007f, 16'h000f, 16'hffff, 16'h017f, 16'h009f, 16'h0010,
         16'h0001, 16'h0000};
      rst = '{16'h0028, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1e00, 16'h0, 16'h0, 16'h0, 16'h0};
      void'($urandom(86));
      HOST.clk_run(1'b1);
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      HOST.clk_run(1'b0);
      repeat (2) @(posedge ref_clk);
      check({11'h0, msb_delay}, 16'h0001, "msb reset");
      check({11'h0, word_bits}, 16'h0018, "word reset");
      check({14'h0, rate_converter_line}, 16'h0003, "line reset");
      check({13'h0, bclk_oe_n, fclk_oe_n, mclk_oe_n}, 16'h0007, "pins reset");
      for (int i = 0; i < 11; i++) begin
         if (i < 10) check(cfg(i), rst[i], "output reset");
         rd(i, rst[i]);
      end
      $display("test reset done");
      for (int p = 0; p < 8; p++) begin
         for (int i = 0; i < 11; i++) begin
            d = 16'($urandom);
            if (i == 1) d[4:0] = {3'(p), 2'(p)};
            if (i == 3) d[6:5] = 2'(p);
            if (i == 6) d[6] = p[0];
            e = (d & msk[i]) | ((i == 6) ? 16'h1e00 : 16'h0000);
            wr(i, d);
            repeat (3) @(posedge ref_clk);
            if (i < 10) check(cfg(i), e, "output field");
            if (i == 1) begin
               check({11'h0, msb_delay}, {11'h0, msb_exp(d[4:2])}, "msb delay");
               check({11'h0, word_bits}, (d[1:0] == 2'h0) ? 16'h0018 : ((d[1:0] == 2'h1) ? 16'h0014 : 16'h0010), "word bits");
               check({14'h0, bclk_oe_n, fclk_oe_n}, {14'h0, ~d[11], ~d[11]}, "clock pins");
            end
            if (i == 3) check({14'h0, rate_converter_line}, {14'h0, 2'h3 - d[6:5]}, "line select");
            if (i == 6) check({15'h0, mclk_oe_n}, {15'h0, ~d[6]}, "master clock pin");
            rd(i, e);
         end
      end
      $display("test write readback done");
      rate_converter_lock <= 1'b1;
      repeat (8) @(posedge ref_clk);
      wr(6, 16'h0000);
      rd(6, 16'h1e80);
      check(cfg(6), 16'h1e80, "lock flag");
      rate_converter_lock <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(6, 16'h1e00);
      $display("test lock done");
      wr(1, 16'h0020);
      wr(8, 16'h0010);
      wr(9, 16'h0001);
      repeat (3) @(posedge ref_clk);
      check({14'h0, output_amp_chop_off, headphone_amp_chop_off}, 16'h0003, "chopping off");
      check({15'h0, sout_cfg.tdm_en}, 16'h0001, "tdm enable");
      $display("test host setup done");
      check(16'(expq.size()), 16'h0000, "reads answered");
      check(16'(HOST.timeouts), 16'h0000, "link answers in time");
      results();
   end
endmodule // audc_regs_tb
